// ---- slm_lmfc_gen.sv ----
// Local multiframe clock generator with reload on realignment.
// Assumes the realign pulse comes from a reference edge already on pclk.
`timescale 1ns/1ps
module slm_lmfc_gen import slm_pkg::*; #(
	parameter int unsigned LMFC_PERIOD  = DEF_LMFC_PERIOD,
	parameter int unsigned FRAME_CYCLES = DEF_FRAME_CYCLES
) (
	// Clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// Alignment request
	input  wire logic             realign,
	input  wire logic [OFS_W-1:0] fine_ofs,
	input  wire logic [FRM_W-1:0] frame_ofs,
	// Multiframe clock
	output logic                  lmfc_edge,
	output logic                  lmfc_level
);
	logic [OFS_W-1:0] left_q, left_d;
	logic             level_q, level_d;
	logic [31:0]      total;

	// Countdown to the next rising edge; realign reloads the distance
	always_comb begin
		total   = 32'(fine_ofs) + 32'(frame_ofs) * FRAME_CYCLES;
		left_d  = (left_q == '0) ? OFS_W'(LMFC_PERIOD - 1) : left_q - 1'b1;
		if (realign) begin
			left_d = OFS_W'(total % LMFC_PERIOD);
		end
		level_d = (32'(left_d) >= LMFC_PERIOD / 2);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			left_q  <= '0;
			level_q <= 1'b0;
		end else begin
			left_q  <= left_d;
			level_q <= level_d;
		end
	end

	assign lmfc_edge  = (left_q == '0);
	assign lmfc_level = level_q;
endmodule // slm_lmfc_gen

// ---- slm_monitor_sva.sv ----
// Port-level checks for the reference-alignment monitor.
// Assumes one clock domain, pclk, and the asynchronous active-low presetn.
`timescale 1ns/1ps
module slm_monitor_sva import slm_pkg::*; #(
	parameter int unsigned LMFC_PERIOD  = DEF_LMFC_PERIOD,
	parameter int unsigned FRAME_CYCLES = DEF_FRAME_CYCLES
) (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB slave
	input wire logic [11:0] paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Reference, multiframe clock, interrupt
	input wire logic        sysref_pin,
	input wire logic        lmfc_out,
	input wire logic        irq
);
	// ----------------------------------------------------------------
	// Read decode
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Access cycle of a read, when prdata is meant to be valid
	wire logic rd = pready && psel && penable && !pwrite;

	function automatic logic at(input logic [7:0] i);
		return paddr == {2'b00, i, 2'b00};
	endfunction

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_ready_follows: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_ready_cause: assert property (pready |-> penable && $past(psel && !penable))
		else $error("ready without a setup cycle");
	a_err_data: assert property (rd && pslverr |-> prdata == 32'h0)
		else $error("refused read returned data");
	a_upper_zero: assert property (rd |-> prdata[31:8] == 24'h0)
		else $error("read data above bit 7");
	a_nibble_high: assert property (rd && (at(IDX_TGT_HI) || at(IDX_MEAS_HI)
		|| at(IDX_PHASE_HI)) |-> prdata[7:4] == 4'h0) else $error("high nibble not zero");
	a_meas_lsb: assert property (rd && at(IDX_MEAS_LO) |-> prdata[1:0] == 2'b00)
		else $error("measured offset low bits set");
	a_tol_width: assert property (rd && at(IDX_JITTER_TOL) |-> prdata[7:6] == 2'b00)
		else $error("tolerance wider than six bits");
	a_mode_width: assert property (rd && at(IDX_SYNC_CTRL) |-> prdata[7:2] == 6'h00)
		else $error("mode wider than two bits");
	// Read data was taken at the setup edge, so compare with the interrupt of that cycle
	a_irq_masked: assert property (rd && at(IDX_IRQ_MASK) && !prdata[4] |-> !$past(irq))
		else $error("interrupt while masked");
	a_irq_quiet: assert property (rd && at(IDX_IRQ_STATUS) && !prdata[4] |-> !$past(irq))
		else $error("interrupt without alarm");

	// Main scenarios reached
	c_read_err: cover property (rd && pslverr);
	c_irq_rise: cover property ($rose(irq));
	c_lmfc_rise: cover property ($rose(lmfc_out));
endmodule // slm_monitor_sva

bind slm_sysref_monitor slm_monitor_sva #(
	.LMFC_PERIOD (LMFC_PERIOD),
	.FRAME_CYCLES(FRAME_CYCLES)
) u_sva (
	.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .sysref_pin(sysref_pin), .lmfc_out(lmfc_out), .irq(irq)
);

// ---- slm_pkg.sv ----
// Shared constants, types and decode helpers for the reference-alignment monitor.
// Assumes a 32-bit APB slave where each register holds one aligned word.
package slm_pkg;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_IRQ_MASK   = 8'h20;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'h24;
	localparam logic [7:0] IDX_FRAME_OFS  = 8'h31;
	localparam logic [7:0] IDX_TGT_LO     = 8'h32;
	localparam logic [7:0] IDX_TGT_HI     = 8'h33;
	localparam logic [7:0] IDX_MEAS_LO    = 8'h34;
	localparam logic [7:0] IDX_MEAS_HI    = 8'h35;
	localparam logic [7:0] IDX_TALLY      = 8'h36;
	localparam logic [7:0] IDX_PHASE_LO   = 8'h37;
	localparam logic [7:0] IDX_PHASE_HI   = 8'h38;
	localparam logic [7:0] IDX_JITTER_TOL = 8'h39;
	localparam logic [7:0] IDX_SYNC_CTRL  = 8'h3A;

	// ----------------------------------------------------------------
	// Field layout and reset values
	// ----------------------------------------------------------------
	localparam int unsigned BIT_JITTER_ALARM = 4;
	localparam int unsigned MEAS_DROP_LSBS   = 2;
	localparam int unsigned JIT_DROP_LSBS    = 2;
	localparam int unsigned OFS_W            = 12;
	localparam int unsigned FRM_W            = 5;
	localparam int unsigned JIT_W            = 6;
	localparam int unsigned TALLY_W          = 8;
	localparam logic [7:0]  REG_RESET        = 8'h00;

	// ----------------------------------------------------------------
	// Timing defaults, in DAC clock periods
	// ----------------------------------------------------------------
	localparam int unsigned DEF_LMFC_PERIOD  = 32;
	localparam int unsigned DEF_FRAME_CYCLES = 4;

	// Synchronization modes, in field order
	typedef enum logic [1:0] {
		SLM_MODE_MONITOR,
		SLM_MODE_CONTINUOUS,
		SLM_MODE_ONESHOT,
		SLM_MODE_SPARE
	} slm_mode_t;

	// Word-aligned register hit
	function automatic logic slm_hit(input logic [11:0] addr, input logic [7:0] idx);
		return (addr[11:2] == {2'b00, idx}) && (addr[1:0] == 2'b00);
	endfunction

	// Thermometer code of a 4-bit level, clipped at twelve
	function automatic logic [11:0] slm_therm(input logic [3:0] lvl);
		logic [11:0] t;
		t = 12'h000;
		for (int i = 0; i < 12; i++) begin
			t[i] = (32'(lvl) > i);
		end
		return t;
	endfunction

endpackage

// ---- slm_ref_source.sv ----
// Model of the external reference source driving the reference pin.
// Assumes the bench enables it and shifts its phase between pulses.
`timescale 1ns/1ps
module slm_ref_source (
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Control from the bench
	input  wire logic       en,
	input  wire logic [6:0] skew,
	// Reference pin
	output logic            sysref_pin
);
	// ----------------------------------------------------------------
	// Pulse timing
	// ----------------------------------------------------------------
	logic [6:0] cnt_q;

	// Period of 128 keeps each pulse on one multiframe phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q      <= 7'h00;
			sysref_pin <= 1'b0;
		end else begin
			cnt_q      <= cnt_q + 7'h01;
			sysref_pin <= en && (7'(cnt_q - skew) < 7'h03); // Three cycles beat the minimum
		end
	end
endmodule // slm_ref_source

// ---- slm_sync_edge.sv ----
// Two-stage synchroniser with rising-edge detection for the reference pin.
// Assumes the pin is asynchronous to pclk and pulses stay high two cycles.
`timescale 1ns/1ps
module slm_sync_edge (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Pin and event
	input  wire logic pin_async,
	output logic      rise
);
	logic meta_q, sync_q, last_q;

	// Only the second stage and its copy feed the edge detector
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			meta_q <= pin_async;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	assign rise = sync_q & ~last_q;
endmodule // slm_sync_edge

// ---- slm_sysref_monitor.sv ----
// Reference-to-multiframe alignment monitor with APB register access.
// Assumes pclk is the DAC clock and the reference pin is asynchronous.
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module slm_sysref_monitor import slm_pkg::*; #(
	parameter int unsigned LMFC_PERIOD  = DEF_LMFC_PERIOD,
	parameter int unsigned FRAME_CYCLES = DEF_FRAME_CYCLES
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Reference and multiframe clock
	input  wire logic        sysref_pin,
	output logic             lmfc_out,
	// Interrupt
	output logic             irq
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (LMFC_PERIOD < 4 || LMFC_PERIOD > 4096) begin : g_bad_period
		$error("LMFC_PERIOD must lie between 4 and 4096");
	end
	if (FRAME_CYCLES < 1 || FRAME_CYCLES > 128) begin : g_bad_frame
		$error("FRAME_CYCLES must lie between 1 and 128");
	end

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic               ref_rise;
	logic               lmfc_edge;
	logic               lmfc_level;
	logic               realign;

	logic [OFS_W-1:0]   tgt_q, tgt_d;
	logic [FRM_W-1:0]   frm_q, frm_d;
	logic [JIT_W-1:0]   jit_q, jit_d;
	slm_mode_t          mode_q, mode_d;
	logic               mask_q, mask_d;
	logic               alarm_q, alarm_d;

	logic [TALLY_W-1:0] tally_q, tally_d;
	logic [OFS_W-1:0]   cnt_q, cnt_d;
	logic               run_q, run_d;
	logic [OFS_W-1:0]   meas_q, meas_d;
	logic [11:0]        phase_q, phase_d;
	logic [OFS_W-1:0]   prev_q, prev_d;
	logic               prev_vld_q, prev_vld_d;

	logic [OFS_W-1:0]   hold_meas_q, hold_meas_d;
	logic [TALLY_W-1:0] hold_tally_q, hold_tally_d;
	logic [11:0]        hold_phase_q, hold_phase_d;

	logic [31:0]        prdata_q, prdata_d;
	logic               pready_q, pready_d;
	logic               pslverr_q, pslverr_d;
	logic               irq_q, irq_d;
	logic               lmfc_q, lmfc_d;

	logic               setup;
	logic               wr_take;
	logic [OFS_W-1:0]   meas_new;
	logic [OFS_W-1:0]   diff;
	logic [OFS_W-1:0]   window;
	logic               too_big;
	logic               mapped;
	logic [7:0]         rd_byte;

	// ----------------------------------------------------------------
	// Reference pin and multiframe clock
	// ----------------------------------------------------------------
	slm_sync_edge u_sync (
		.pclk      (pclk),
		.presetn   (presetn),
		.pin_async (sysref_pin),
		.rise      (ref_rise)
	);

	// Monitor mode never moves the LMFC
	assign realign = ref_rise &&
		(mode_q == SLM_MODE_CONTINUOUS || mode_q == SLM_MODE_ONESHOT);

	// Fine and coarse offsets combine into one reload distance
	slm_lmfc_gen #(
		.LMFC_PERIOD  (LMFC_PERIOD),
		.FRAME_CYCLES (FRAME_CYCLES)
	) u_lmfc (
		.pclk       (pclk),
		.presetn    (presetn),
		.realign    (realign),
		.fine_ofs   (tgt_q),
		.frame_ofs  (frm_q),
		.lmfc_edge  (lmfc_edge),
		.lmfc_level (lmfc_level)
	);

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	// Write takes effect only at the completing access edge
	assign setup   = psel & ~penable;
	assign wr_take = psel & penable & pwrite & pready_q;

	// Read mux; snapshot copies keep multi-byte reads coherent
	always_comb begin
		mapped  = 1'b1;
		rd_byte = REG_RESET;
		if (slm_hit(paddr, IDX_IRQ_MASK)) begin
			rd_byte[BIT_JITTER_ALARM] = mask_q;
		end else if (slm_hit(paddr, IDX_IRQ_STATUS)) begin
			rd_byte[BIT_JITTER_ALARM] = alarm_q;
		end else if (slm_hit(paddr, IDX_FRAME_OFS)) begin
			rd_byte = {3'h0, frm_q};
		end else if (slm_hit(paddr, IDX_TGT_LO)) begin
			rd_byte = tgt_q[7:0];
		end else if (slm_hit(paddr, IDX_TGT_HI)) begin
			rd_byte = {4'h0, tgt_q[11:8]};
		end else if (slm_hit(paddr, IDX_MEAS_LO)) begin
			rd_byte = hold_meas_q[7:0];
		end else if (slm_hit(paddr, IDX_MEAS_HI)) begin
			rd_byte = {4'h0, hold_meas_q[11:8]};
		end else if (slm_hit(paddr, IDX_TALLY)) begin
			rd_byte = hold_tally_q;
		end else if (slm_hit(paddr, IDX_PHASE_LO)) begin
			rd_byte = hold_phase_q[7:0];
		end else if (slm_hit(paddr, IDX_PHASE_HI)) begin
			rd_byte = {4'h0, hold_phase_q[11:8]};
		end else if (slm_hit(paddr, IDX_JITTER_TOL)) begin
			rd_byte = {2'h0, jit_q};
		end else if (slm_hit(paddr, IDX_SYNC_CTRL)) begin
			rd_byte = {6'h00, mode_q};
		end else begin
			mapped = 1'b0;
		end
	end

	// Answer one cycle after setup: zero wait states
	always_comb begin
		pready_d  = 1'b0;
		pslverr_d = 1'b0;
		prdata_d  = prdata_q;
		if (setup) begin
			pready_d  = 1'b1;
			pslverr_d = ~mapped;
			prdata_d  = pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
		end
	end

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	always_comb begin
		tgt_d  = tgt_q;
		frm_d  = frm_q;
		jit_d  = jit_q;
		mask_d = mask_q;
		mode_d = mode_q;
		// One-shot drops back to monitor once used
		if (ref_rise && mode_q == SLM_MODE_ONESHOT) begin
			mode_d = SLM_MODE_MONITOR;
		end
		if (wr_take) begin
			if (slm_hit(paddr, IDX_TGT_LO)) begin
				tgt_d[7:0] = pwdata[7:0];
			end
			if (slm_hit(paddr, IDX_TGT_HI)) begin
				tgt_d[11:8] = pwdata[3:0];
			end
			if (slm_hit(paddr, IDX_FRAME_OFS)) begin
				frm_d = pwdata[4:0];
			end
			if (slm_hit(paddr, IDX_JITTER_TOL)) begin
				jit_d = pwdata[5:0];
			end
			if (slm_hit(paddr, IDX_IRQ_MASK)) begin
				mask_d = pwdata[BIT_JITTER_ALARM];
			end
			if (slm_hit(paddr, IDX_SYNC_CTRL)) begin
				mode_d = slm_mode_t'(pwdata[1:0]);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tgt_q  <= '0;
			frm_q  <= '0;
			jit_q  <= '0;
			mask_q <= 1'b0;
			mode_q <= SLM_MODE_MONITOR;
		end else begin
			tgt_q  <= tgt_d;
			frm_q  <= frm_d;
			jit_q  <= jit_d;
			mask_q <= mask_d;
			mode_q <= mode_d;
		end
	end

	// ----------------------------------------------------------------
	// Measurement, tally, phase and jitter
	// ----------------------------------------------------------------
	// Quantised result; the comparison ignores tolerance LSBs too
	assign meas_new = {cnt_q[OFS_W-1:MEAS_DROP_LSBS], 2'b00};
	assign window   = OFS_W'({jit_q[JIT_W-1:JIT_DROP_LSBS], 2'b00});
	assign diff     = (meas_new >= prev_q) ? meas_new - prev_q : prev_q - meas_new;
	assign too_big  = run_q && lmfc_edge && prev_vld_q && (diff > window);

	always_comb begin
		cnt_d      = cnt_q;
		run_d      = run_q;
		meas_d     = meas_q;
		phase_d    = phase_q;
		prev_d     = prev_q;
		prev_vld_d = prev_vld_q;
		// Close the running measurement at the LMFC edge
		if (run_q && lmfc_edge) begin
			run_d      = 1'b0;
			meas_d     = meas_new;
			phase_d    = slm_therm(cnt_q[3:0]);
			prev_d     = meas_new;
			prev_vld_d = 1'b1;
		end else if (run_q && cnt_q != '1) begin
			cnt_d = cnt_q + 1'b1;
		end
		// A new event restarts the count, even over a pending one
		if (ref_rise) begin
			run_d = 1'b1;
			cnt_d = '0;
		end
	end

	// Tally: a clearing write in the event cycle keeps that event
	always_comb begin
		tally_d = tally_q + TALLY_W'(ref_rise);
		if (wr_take && slm_hit(paddr, IDX_TALLY)) begin
			tally_d = TALLY_W'(ref_rise);
		end
	end

	// Sticky alarm; a new detection wins over the clearing write
	always_comb begin
		alarm_d = alarm_q;
		if (wr_take && slm_hit(paddr, IDX_IRQ_STATUS) && pwdata[BIT_JITTER_ALARM]) begin
			alarm_d = 1'b0;
		end
		if (too_big) begin
			alarm_d = 1'b1;
		end
		irq_d = alarm_d & mask_d;
	end

	// Snapshot on a write to any measured-offset or phase byte
	always_comb begin
		hold_meas_d  = hold_meas_q;
		hold_tally_d = hold_tally_q;
		hold_phase_d = hold_phase_q;
		if (wr_take && (slm_hit(paddr, IDX_MEAS_LO) || slm_hit(paddr, IDX_MEAS_HI) ||
			slm_hit(paddr, IDX_PHASE_LO) || slm_hit(paddr, IDX_PHASE_HI))) begin
			hold_meas_d  = meas_q;
			hold_tally_d = tally_q;
			hold_phase_d = phase_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q        <= '0;
			run_q        <= 1'b0;
			meas_q       <= '0;
			phase_q      <= '0;
			prev_q       <= '0;
			prev_vld_q   <= 1'b0;
			tally_q      <= '0;
			alarm_q      <= 1'b0;
			hold_meas_q  <= '0;
			hold_tally_q <= '0;
			hold_phase_q <= '0;
		end else begin
			cnt_q        <= cnt_d;
			run_q        <= run_d;
			meas_q       <= meas_d;
			phase_q      <= phase_d;
			prev_q       <= prev_d;
			prev_vld_q   <= prev_vld_d;
			tally_q      <= tally_d;
			alarm_q      <= alarm_d;
			hold_meas_q  <= hold_meas_d;
			hold_tally_q <= hold_tally_d;
			hold_phase_q <= hold_phase_d;
		end
	end

	// ----------------------------------------------------------------
	// Output flops
	// ----------------------------------------------------------------
	// Level copy keeps the pin one flop from the generator
	assign lmfc_d = lmfc_level;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q  <= 32'h0000_0000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			irq_q     <= 1'b0;
			lmfc_q    <= 1'b0;
		end else begin
			prdata_q  <= prdata_d;
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
			irq_q     <= irq_d;
			lmfc_q    <= lmfc_d;
		end
	end

	assign prdata   = prdata_q;
	assign pready   = pready_q;
	assign pslverr  = pslverr_q;
	assign irq      = irq_q;
	assign lmfc_out = lmfc_q;

endmodule // slm_sysref_monitor

// ---- tb_slm_sysref_monitor.sv ----
// Self-checking bench for the reference-alignment monitor.
// Assumes the reference source model and the bound port checker.
`timescale 1ns/1ps
module tb_slm_sysref_monitor import slm_pkg::*; ();
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic        pclk     = 1'b0;
	logic        presetn  = 1'b0;
	logic [11:0] paddr    = 12'h000;
	logic        psel     = 1'b0;
	logic        penable  = 1'b0;
	logic        pwrite   = 1'b0;
	logic [31:0] pwdata   = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        sysref_pin;
	logic        lmfc_out;
	logic        irq;
	logic        ref_en   = 1'b0;
	logic [6:0]  ref_skew = 7'h00;
	logic [31:0] rdat;
	logic        rerr;
	int          error_cnt = 0;
	int          n_checks  = 0;
	int          cyc       = 0;
	int          nper;
	logic [7:0]  regs[12] = '{IDX_IRQ_MASK, IDX_IRQ_STATUS, IDX_FRAME_OFS, IDX_TGT_LO,
		IDX_TGT_HI, IDX_MEAS_LO, IDX_MEAS_HI, IDX_TALLY, IDX_PHASE_LO, IDX_PHASE_HI,
		IDX_JITTER_TOL, IDX_SYNC_CTRL};
	logic [7:0]  acc_idx[5] = '{IDX_TGT_LO, IDX_TGT_HI, IDX_JITTER_TOL, IDX_SYNC_CTRL,
		IDX_FRAME_OFS};
	logic [7:0]  acc_exp[5] = '{8'hFF, 8'h0F, 8'h3F, 8'h03, 8'h1F};

	always #5 pclk = ~pclk;

	slm_sysref_monitor #(.LMFC_PERIOD(32), .FRAME_CYCLES(4)) dut (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sysref_pin(sysref_pin), .lmfc_out(lmfc_out), .irq(irq)
	);

	slm_ref_source u_ref (
		.pclk(pclk), .presetn(presetn), .en(ref_en), .skew(ref_skew),
		.sysref_pin(sysref_pin)
	);

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic stop_test();
		if (error_cnt == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	function automatic logic [11:0] ba(input logic [7:0] i);
		return {2'b00, i, 2'b00};
	endfunction

	// One APB transfer, entered right after a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d});
	endtask

	task automatic rd(input logic [11:0] a, input logic [7:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rdat, {24'h0, exp});
	endtask

	// Clock cycles between two rising edges of the multiframe clock
	task automatic lmfc_period(output int n);
		realtime t0;
		@(posedge lmfc_out);
		t0 = $realtime;
		@(posedge lmfc_out);
		n = int'(($realtime - t0) / 10.0);
	endtask

	// Mid-period after each pulse, so measurements have settled
	task automatic wait_ref(input int n);
		repeat (n) begin
			@(posedge sysref_pin);
			repeat (60) @(posedge pclk);
		end
	endtask

	// ----------------------------------------------------------------
	// Timeout and main sequence
	// ----------------------------------------------------------------
	always @(posedge pclk) begin
		cyc++;
		if (cyc > 20000) begin
			error_cnt++;
			stop_test();
		end
	end

	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (regs[i]) rd(ba(regs[i]), 8'h00);
		foreach (acc_idx[i]) begin
			wr(ba(acc_idx[i]), 8'hFF);
			rd(ba(acc_idx[i]), acc_exp[i]);
		end
		apb(1'b0, 12'hFFC, 32'h0);
		chk({31'h0, rerr}, 32'h1);
		chk(rdat, 32'h0);
		// Continuous alignment at 22 clocks reads back as 20
		wr(ba(IDX_TGT_LO), 8'd22);
		wr(ba(IDX_FRAME_OFS), 8'h00);
		wr(ba(IDX_SYNC_CTRL), 8'h01);
		ref_en <= 1'b1;
		wait_ref(2);
		wr(ba(IDX_MEAS_LO), 8'h00);
		rd(ba(IDX_MEAS_LO), 8'h14);
		rd(ba(IDX_MEAS_HI), 8'h00);
		apb(1'b0, ba(IDX_PHASE_LO), 32'h0);
		chk(rdat & (rdat + 32'h1), 32'h0);
		// Monitor mode leaves the old alignment alone
		wr(ba(IDX_SYNC_CTRL), 8'h00);
		wr(ba(IDX_TGT_LO), 8'd6);
		wr(ba(IDX_FRAME_OFS), 8'h01);
		wait_ref(2);
		wr(ba(IDX_MEAS_HI), 8'h00);
		rd(ba(IDX_MEAS_LO), 8'h14);
		// One-shot moves once to 6 clocks plus one frame, then falls back to monitor
		wr(ba(IDX_SYNC_CTRL), 8'h02);
		wait_ref(1);
		rd(ba(IDX_SYNC_CTRL), 8'h00);
		wr(ba(IDX_PHASE_LO), 8'h00);
		rd(ba(IDX_MEAS_LO), 8'h08);
		wr(ba(IDX_TGT_LO), 8'd22);
		wait_ref(1);
		wr(ba(IDX_PHASE_HI), 8'h00);
		rd(ba(IDX_MEAS_LO), 8'h08);
		// Tally clears on any write and counts each pulse
		wr(ba(IDX_TALLY), 8'hA5);
		wr(ba(IDX_MEAS_LO), 8'h00);
		rd(ba(IDX_TALLY), 8'h00);
		wait_ref(3);
		wr(ba(IDX_MEAS_LO), 8'h00);
		rd(ba(IDX_TALLY), 8'h03);
		// Phase step of 8 clocks beats a tolerance of 4
		wr(ba(IDX_JITTER_TOL), 8'h07);
		wr(ba(IDX_IRQ_MASK), 8'h10);
		rd(ba(IDX_IRQ_STATUS), 8'h00);
		ref_skew <= 7'd8;
		wait_ref(2);
		chk({31'h0, irq}, 32'h1);
		rd(ba(IDX_IRQ_STATUS), 8'h10);
		wr(ba(IDX_IRQ_STATUS), 8'h10);
		rd(ba(IDX_IRQ_STATUS), 8'h00);
		chk({31'h0, irq}, 32'h0);
		ref_skew <= 7'd0;
		wait_ref(2);
		rd(ba(IDX_IRQ_STATUS), 8'h10);
		wr(ba(IDX_IRQ_MASK), 8'h00);
		chk({31'h0, irq}, 32'h0);
		// Free-running multiframe clock keeps its 32-cycle period
		lmfc_period(nper);
		chk(nper, 32'd32);
		stop_test();
	end
endmodule // tb_slm_sysref_monitor
